// ===== aea_alarm.sv
// Absolute encoder alarm detection, deferral, latching and reporting
// Functional notes
// - Encoder error: code 80, all outputs off
// - Back-up error: code 81, all outputs off
// - Sum-check error: code 82, all outputs off
// - Battery error: code 83, all outputs off
// - Back-up error needs supply, battery, capacitor failed
// - Sum-check while running first shows code 80
// - Code 82 only after sensor request/power cycle
// - Serial listener sees sum-check during operation
// - Battery error while running raises no alarm
// - Deferred battery alarm at sensor rise or power-on
// - Serial listener sees battery error during operation
// - Low or missing battery is battery error
// - Sensor toggle clears only in speed, bit 0
// - Output high means transistor conducting
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module aea_alarm (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [aea_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [aea_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic enc_fault_in,
  input wire logic sum_fault_in,
  input wire logic supply_5v_ok,
  input wire logic battery_present,
  input wire logic [15:0] battery_mv,
  input wire logic capacitor_ok,
  input wire logic sensor_request_input,
  input wire logic serial_listen,
  output logic [7:0] display_code,
  output logic alarm_code_bit_one,
  output logic alarm_code_bit_two,
  output logic alarm_code_bit_three,
  output logic alarm_out,
  output logic [3:0] serial_status
);
  typedef struct packed {
    aea_pkg::aea_state_t st;
    logic [2:0] boot_cnt;
    logic latched;
    logic [7:0] code;
    logic pend_sum;
    logic pend_batt;
    logic sen_prev;
    logic sum_prev;
    logic pos_mode;
    logic enc_mode;
    logic [15:0] thr;
    logic [3:0] serial;
    logic [2:0] code_bits;
    logic alarm_on;
  } aea_alarm_t;
  aea_alarm_t r_q, r_d;

  logic [22:0] pins_s;
  logic enc_s, sum_s, s5_s, bpres_s, cap_s, sen_s, listen_s;
  logic [15:0] mv_s;
  logic batt_cond, bkup_cond, sen_rise, sum_new, clr_ok;
  logic wr_en, wr_ok, rd_ok;
  logic [aea_pkg::ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  // Three-bit output pattern for a display code; all encoder alarms drive every bit off
  function automatic logic [2:0] code_pattern(input logic [7:0] code);
    code_pattern = 3'h0;
    if (code == aea_pkg::CODE_NONE) begin
      code_pattern = 3'h0;
    end
  endfunction

  // Address decode, shared by the write and read paths
  function automatic logic mapped(input logic [aea_pkg::ADDR_W-1:0] a);
    mapped = (a == aea_pkg::OFF_CTRL) || (a == aea_pkg::OFF_STATUS) || (a == aea_pkg::OFF_THR);
  endfunction

  // Every pin passes two flops; battery voltage is assumed to be quasi-static
  aea_sync #(
    .W(23)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d({enc_fault_in, sum_fault_in, supply_5v_ok, battery_present, capacitor_ok,
        sensor_request_input, serial_listen, battery_mv}),
    .q(pins_s)
  );
  assign {enc_s, sum_s, s5_s, bpres_s, cap_s, sen_s, listen_s, mv_s} = pins_s;

  aea_axil u_axil (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Fault conditions derived from the synchronised pins
  assign batt_cond = !bpres_s || (mv_s < r_q.thr);
  assign bkup_cond = !s5_s && batt_cond && !cap_s;
  assign sen_rise = sen_s && !r_q.sen_prev;
  assign sum_new = sum_s && !r_q.sum_prev;
  assign clr_ok = !r_q.pos_mode && !r_q.enc_mode;

  // Register read mux and write acceptance
  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(rd_addr);
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_addr == aea_pkg::OFF_CTRL) begin
      rd_data[aea_pkg::CTRL_POS_MODE_BIT] = r_q.pos_mode;
      rd_data[aea_pkg::CTRL_ENC_MODE_BIT] = r_q.enc_mode;
    end else if (rd_addr == aea_pkg::OFF_STATUS) begin
      rd_data[aea_pkg::ST_CODE_LSB +: 8] = r_q.code;
      rd_data[aea_pkg::ST_LATCH_BIT] = r_q.latched;
      rd_data[aea_pkg::ST_PSUM_BIT] = r_q.pend_sum;
      rd_data[aea_pkg::ST_PBATT_BIT] = r_q.pend_batt;
      rd_data[aea_pkg::ST_LIVE_LSB +: 4] = {batt_cond, sum_s, bkup_cond, enc_s};
    end else if (rd_addr == aea_pkg::OFF_THR) begin
      rd_data[15:0] = r_q.thr;
    end
  end

  // Alarm state machine: clear step, deferred step, then live faults; each only latches into a free slot, so earlier sets win
  always_comb begin
    r_d = r_q;
    if (wr_en && wr_addr == aea_pkg::OFF_CTRL && wr_strb[0]) begin
      r_d.pos_mode = wr_data[aea_pkg::CTRL_POS_MODE_BIT];
      r_d.enc_mode = wr_data[aea_pkg::CTRL_ENC_MODE_BIT];
    end
    if (wr_en && wr_addr == aea_pkg::OFF_THR) begin
      if (wr_strb[0]) begin
        r_d.thr[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        r_d.thr[15:8] = wr_data[15:8];
      end
    end
    unique case (r_q.st)
      aea_pkg::AEA_BOOT: begin
        // Wait for the synchronisers to fill before judging the power-on state
        if (r_q.boot_cnt != aea_pkg::BOOT_CYC) begin
          r_d.boot_cnt = r_q.boot_cnt + 3'h1;
        end else begin
          r_d.st = aea_pkg::AEA_RUN;
          r_d.latched = 1'b1;
          if (bkup_cond) begin
            r_d.code = aea_pkg::CODE_BKUP;
          end else if (enc_s) begin
            r_d.code = aea_pkg::CODE_ENC;
          end else if (sum_s) begin
            r_d.code = aea_pkg::CODE_SUM;
          end else if (batt_cond) begin
            r_d.code = aea_pkg::CODE_BATT;
          end else begin
            r_d.latched = 1'b0;
          end
        end
      end
      aea_pkg::AEA_RUN: begin
        if (sen_rise) begin
          if (clr_ok) begin
            r_d.latched = 1'b0;
            r_d.code = aea_pkg::CODE_NONE;
          end
          // Deferred reports surface only once the slot is free
          if (!r_d.latched && (r_q.pend_sum || sum_s)) begin
            r_d.latched = 1'b1;
            r_d.code = aea_pkg::CODE_SUM;
            r_d.pend_sum = 1'b0;
          end else if (!r_d.latched && (r_q.pend_batt || batt_cond)) begin
            r_d.latched = 1'b1;
            r_d.code = aea_pkg::CODE_BATT;
            r_d.pend_batt = 1'b0;
          end
        end
        if (!r_d.latched && bkup_cond) begin
          r_d.latched = 1'b1;
          r_d.code = aea_pkg::CODE_BKUP;
        end else if (!r_d.latched && (enc_s || sum_new)) begin
          r_d.latched = 1'b1;
          r_d.code = aea_pkg::CODE_ENC;
        end
        if (sum_new) begin
          r_d.pend_sum = 1'b1;
        end
        if (batt_cond && !sen_rise) begin
          r_d.pend_batt = 1'b1;
        end
      end
    endcase
    r_d.sen_prev = sen_s;
    r_d.sum_prev = sum_s;
    // Live conditions stream to a host that is listening to serial data
    r_d.serial = listen_s ? {batt_cond, sum_s, bkup_cond, enc_s} : 4'h0;
    // Pins are active high: 1 turns the transistor on; summary is on while healthy
    r_d.code_bits = code_pattern(r_d.code);
    r_d.alarm_on = !r_d.latched;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{st: aea_pkg::AEA_BOOT, thr: aea_pkg::THR_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign display_code = r_q.code;
  assign {alarm_code_bit_three, alarm_code_bit_two, alarm_code_bit_one} = r_q.code_bits;
  assign alarm_out = r_q.alarm_on;
  assign serial_status = r_q.serial;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_sum_hit;
    r_q.st == aea_pkg::AEA_RUN && sum_new && !r_q.latched && !sen_rise && !bkup_cond;
  endsequence
  sequence s_batt_quiet;
    r_q.st == aea_pkg::AEA_RUN && batt_cond && !r_q.latched && !sen_rise && !bkup_cond
      && !enc_s && !sum_new;
  endsequence

  AST_ENC_OUTS: assert property (display_code == aea_pkg::CODE_ENC |->
      !alarm_code_bit_one && !alarm_code_bit_two && !alarm_code_bit_three && !alarm_out)
    else $error("encoder error outputs not all off");
  AST_BKUP_OUTS: assert property (display_code == aea_pkg::CODE_BKUP |->
      {alarm_code_bit_one, alarm_code_bit_two, alarm_code_bit_three, alarm_out} == 4'h0)
    else $error("back-up error outputs not all off");
  AST_SUM_OUTS: assert property (display_code == aea_pkg::CODE_SUM |->
      !alarm_out && r_q.code_bits == 3'h0)
    else $error("sum-check outputs not all off");
  AST_BATT_OUTS: assert property (display_code == aea_pkg::CODE_BATT |->
      {alarm_code_bit_one, alarm_code_bit_two, alarm_code_bit_three, alarm_out} == 4'h0)
    else $error("battery error outputs not all off");
  AST_BKUP_CAUSE: assert property ($rose(display_code == aea_pkg::CODE_BKUP) |->
      $past(!s5_s && !cap_s && batt_cond))
    else $error("back-up error without all supplies failed");
  AST_SUM_FIRST_ENC: assert property (s_sum_hit |=>
      display_code == aea_pkg::CODE_ENC && r_q.pend_sum)
    else $error("sum-check in run did not show encoder error");
  AST_SUM_DEFER: assert property ($rose(display_code == aea_pkg::CODE_SUM) |->
      $past(sen_rise || r_q.st == aea_pkg::AEA_BOOT))
    else $error("sum-check code shown without sensor or power cycle");
  AST_SERIAL_LIVE: assert property (listen_s |=>
      serial_status[2] == $past(sum_s) && serial_status[3] == $past(batt_cond))
    else $error("serial status missed live conditions");
  AST_BATT_SILENT: assert property (s_batt_quiet |=>
      !r_q.latched && alarm_out && r_q.pend_batt)
    else $error("battery error raised alarm during run");
  AST_BATT_AT_SEN: assert property (r_q.st == aea_pkg::AEA_RUN && sen_rise && clr_ok
      && r_q.pend_batt && !r_q.pend_sum && !sum_s |=> display_code == aea_pkg::CODE_BATT)
    else $error("deferred battery alarm missing at sensor rise");
  AST_NO_SEN_CLEAR: assert property (r_q.latched && sen_rise && !clr_ok |=>
      r_q.latched && $stable(display_code))
    else $error("sensor toggle cleared alarm in power-cycle mode");
  AST_HOLD: assert property (r_q.latched && !sen_rise |=>
      $stable(display_code) [*2] or sen_rise)
    else $error("latched alarm changed without clearing action");
endmodule

// ===== aea_pkg.sv
// Constants and types shared by the absolute encoder alarm block
package aea_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_THR = 8'h08;
  localparam int unsigned CTRL_POS_MODE_BIT = 0;
  localparam int unsigned CTRL_ENC_MODE_BIT = 1;
  localparam int unsigned ST_CODE_LSB = 0;
  localparam int unsigned ST_LATCH_BIT = 8;
  localparam int unsigned ST_PSUM_BIT = 9;
  localparam int unsigned ST_PBATT_BIT = 10;
  localparam int unsigned ST_LIVE_LSB = 12;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_ENC = 8'h80;
  localparam logic [7:0] CODE_BKUP = 8'h81;
  localparam logic [7:0] CODE_SUM = 8'h82;
  localparam logic [7:0] CODE_BATT = 8'h83;
  localparam int unsigned BATT_THR_MV = 2800;
  localparam logic [15:0] THR_RESET = 16'(BATT_THR_MV);
  localparam logic [2:0] BOOT_CYC = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {AEA_BOOT, AEA_RUN} aea_state_t;
endpackage

// ===== aea_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module aea_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } aea_sync_t;
  aea_sync_t r_q, r_d;

  // First stage feeds only the second stage
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule

// ===== aea_axil.sv
// AXI4-Lite slave front end: takes writes and reads, hands writes on as a strobe and reads as a live address
`timescale 1ns/1ps
module aea_axil (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [aea_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [aea_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [aea_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [aea_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  typedef struct packed {
    logic aw_have;
    logic [aea_pkg::ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aea_axil_t;
  aea_axil_t r_q, r_d;

  // Address and data may arrive in either order; no new write until the response leaves
  assign s_awready = !r_q.aw_have && !r_q.bvalid;
  assign s_wready = !r_q.w_have && !r_q.bvalid;
  assign s_arready = !r_q.rvalid;
  assign wr_en = r_q.aw_have && r_q.w_have;
  assign wr_addr = r_q.awaddr;
  assign wr_data = r_q.wdata;
  assign wr_strb = r_q.wstrb;
  assign rd_addr = s_araddr;

  always_comb begin
    r_d = r_q;
    if (s_awvalid && s_awready) begin
      r_d.aw_have = 1'b1;
      r_d.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      r_d.w_have = 1'b1;
      r_d.wdata = s_wdata;
      r_d.wstrb = s_wstrb;
    end
    if (wr_en) begin
      r_d.aw_have = 1'b0;
      r_d.w_have = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = wr_ok ? aea_pkg::RESP_OKAY : aea_pkg::RESP_SLVERR;
    end else if (r_q.bvalid && s_bready) begin
      r_d.bvalid = 1'b0;
    end
    // Read data is captured at the address handshake, unmapped reads return zero
    if (s_arvalid && s_arready) begin
      r_d.rvalid = 1'b1;
      r_d.rdata = rd_ok ? rd_data : 32'h0000_0000;
      r_d.rresp = rd_ok ? aea_pkg::RESP_OKAY : aea_pkg::RESP_SLVERR;
    end else if (r_q.rvalid && s_rready) begin
      r_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign s_bvalid = r_q.bvalid;
  assign s_bresp = r_q.bresp;
  assign s_rvalid = r_q.rvalid;
  assign s_rdata = r_q.rdata;
  assign s_rresp = r_q.rresp;
endmodule

// ===== aea_far_model.sv
// Far side model: host controller and absolute encoder driving the alarm pins
`timescale 1ns/1ps
module aea_far_model (
  input wire logic clk_sys,
  output logic enc_fault_in,
  output logic sum_fault_in,
  output logic supply_5v_ok,
  output logic battery_present,
  output logic [15:0] battery_mv,
  output logic capacitor_ok,
  output logic sensor_request_input,
  output logic serial_listen
);
  logic servo_on;
  // Healthy encoder, sensor request held on, servo running
  initial begin
    enc_fault_in = 1'b0;
    sum_fault_in = 1'b0;
    supply_5v_ok = 1'b1;
    battery_present = 1'b1;
    battery_mv = 16'h0BB8;
    capacitor_ok = 1'b1;
    sensor_request_input = 1'b1;
    serial_listen = 1'b0;
    servo_on = 1'b1;
  end
  // Encoder fault pins change just after an edge
  task automatic set_faults(input logic enc, input logic sum);
    @(posedge clk_sys);
    enc_fault_in <= enc;
    sum_fault_in <= sum;
  endtask
  // A missing battery reads as zero volts, never as the last good level
  task automatic set_power(input logic sup, input logic pres, input logic [15:0] mv,
                           input logic cap);
    @(posedge clk_sys);
    supply_5v_ok <= sup;
    battery_present <= pres;
    battery_mv <= pres ? mv : 16'h0000;
    capacitor_ok <= cap;
  endtask
  task automatic listen(input logic on);
    @(posedge clk_sys);
    serial_listen <= on;
  endtask
  // Clearing toggle: servo is stopped first, then request goes off and back on
  task automatic sensor_cycle();
    servo_on = 1'b0;
    @(posedge clk_sys);
    sensor_request_input <= 1'b0;
    repeat (6) @(posedge clk_sys);
    sensor_request_input <= 1'b1;
    repeat (6) @(posedge clk_sys);
    servo_on = 1'b1;
  endtask
endmodule

// ===== test_abs_encoder_alarm_reporting.sv
// Self-checking bench for the absolute encoder alarm block
`timescale 1ns/1ps
module test_abs_encoder_alarm_reporting;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'h0, serial_status;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, resp;
  logic enc_fault_in, sum_fault_in, supply_5v_ok, battery_present, capacitor_ok;
  logic sensor_request_input, serial_listen;
  logic [15:0] battery_mv;
  logic [7:0] display_code;
  logic alarm_code_bit_one, alarm_code_bit_two, alarm_code_bit_three, alarm_out;
  logic [31:0] rd;
  int fail_count = 0, n_compared = 0, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  aea_alarm dut_u (.clk_sys(clk_sys), .resetn(resetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .enc_fault_in(enc_fault_in), .sum_fault_in(sum_fault_in), .supply_5v_ok(supply_5v_ok),
    .battery_present(battery_present), .battery_mv(battery_mv), .capacitor_ok(capacitor_ok),
    .sensor_request_input(sensor_request_input), .serial_listen(serial_listen),
    .display_code(display_code), .alarm_code_bit_one(alarm_code_bit_one),
    .alarm_code_bit_two(alarm_code_bit_two), .alarm_code_bit_three(alarm_code_bit_three),
    .alarm_out(alarm_out), .serial_status(serial_status));

  aea_far_model far_u (.clk_sys(clk_sys), .enc_fault_in(enc_fault_in),
    .sum_fault_in(sum_fault_in), .supply_5v_ok(supply_5v_ok),
    .battery_present(battery_present), .battery_mv(battery_mv), .capacitor_ok(capacitor_ok),
    .sensor_request_input(sensor_request_input), .serial_listen(serial_listen));

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang anywhere ends the run through the same report
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Code bits stay off for every encoder alarm; summary output conducts only when healthy
  task automatic check_state(input logic [7:0] code, input logic aout);
    check({24'h0, display_code}, {24'h0, code});
    check({29'h0, alarm_code_bit_one, alarm_code_bit_two, alarm_code_bit_three}, 32'h0);
    check({31'h0, alarm_out}, {31'h0, aout});
  endtask

  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask

  // Reset also stands for a drive power cycle; boot needs several edges to judge
  task automatic power_cycle();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (12) @(posedge clk_sys);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (s_awvalid && s_awready) begin
        aw_done = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_done = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    while (!s_bvalid) @(posedge clk_sys);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge clk_sys);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask

  initial begin
    power_cycle();
    check_state(aea_pkg::CODE_NONE, 1'b1);
    axi_read(aea_pkg::OFF_THR, rd, resp);
    check(rd, {16'h0, aea_pkg::THR_RESET});
    // Threshold is writable; restored so later battery steps keep the reset level
    axi_write(aea_pkg::OFF_THR, 32'h0000_0ABC, resp);
    check({30'h0, resp}, {30'h0, aea_pkg::RESP_OKAY});
    axi_read(aea_pkg::OFF_THR, rd, resp);
    check(rd, 32'h0000_0ABC);
    axi_write(aea_pkg::OFF_THR, {16'h0, aea_pkg::THR_RESET}, resp);
    axi_read(8'h0C, rd, resp);
    check({30'h0, resp}, {30'h0, aea_pkg::RESP_SLVERR});
    axi_write(8'h0C, 32'h0000_0003, resp);
    check({30'h0, resp}, {30'h0, aea_pkg::RESP_SLVERR});
    // Encoder error latches and clears by sensor toggle in speed mode
    far_u.set_faults(1'b1, 1'b0);
    settle();
    check_state(aea_pkg::CODE_ENC, 1'b0);
    far_u.set_faults(1'b0, 1'b0);
    settle();
    check_state(aea_pkg::CODE_ENC, 1'b0);
    far_u.sensor_cycle();
    check_state(aea_pkg::CODE_NONE, 1'b1);
    // Sum-check in run shows as encoder error, its own code after the toggle
    far_u.listen(1'b1);
    far_u.set_faults(1'b0, 1'b1);
    settle();
    check_state(aea_pkg::CODE_ENC, 1'b0);
    check({28'h0, serial_status & 4'h4}, 32'h4);
    far_u.sensor_cycle();
    check_state(aea_pkg::CODE_SUM, 1'b0);
    // Status word: latched sum-check code, nothing pending, live sum-check bit
    axi_read(aea_pkg::OFF_STATUS, rd, resp);
    check(rd, (32'h4 << aea_pkg::ST_LIVE_LSB) | (32'h1 << aea_pkg::ST_LATCH_BIT)
      | {24'h0, aea_pkg::CODE_SUM});
    far_u.set_faults(1'b0, 1'b0);
    power_cycle();
    // Battery at the threshold is fine, one millivolt under is an error
    far_u.set_power(1'b1, 1'b1, 16'h0AF0, 1'b1);
    settle();
    check({28'h0, serial_status}, 32'h0);
    far_u.set_power(1'b1, 1'b1, 16'h0AEF, 1'b1);
    settle();
    check_state(aea_pkg::CODE_NONE, 1'b1);
    check({28'h0, serial_status}, 32'h8);
    far_u.listen(1'b0);
    settle();
    check({28'h0, serial_status}, 32'h0);
    far_u.sensor_cycle();
    check_state(aea_pkg::CODE_BATT, 1'b0);
    power_cycle();
    check_state(aea_pkg::CODE_BATT, 1'b0);
    far_u.set_power(1'b1, 1'b0, 16'h0BB8, 1'b1);
    power_cycle();
    check_state(aea_pkg::CODE_BATT, 1'b0);
    // Back-up error needs all three sources gone
    far_u.set_power(1'b0, 1'b0, 16'h0BB8, 1'b1);
    power_cycle();
    check_state(aea_pkg::CODE_BATT, 1'b0);
    far_u.set_power(1'b0, 1'b0, 16'h0BB8, 1'b0);
    power_cycle();
    check_state(aea_pkg::CODE_BKUP, 1'b0);
    far_u.set_power(1'b1, 1'b1, 16'h0BB8, 1'b1);
    power_cycle();
    // Position control or encoder mode bit set: only a power cycle clears
    for (int m = 1; m <= 2; m++) begin
      axi_write(aea_pkg::OFF_CTRL, 32'(m), resp);
      check({30'h0, resp}, {30'h0, aea_pkg::RESP_OKAY});
      axi_read(aea_pkg::OFF_CTRL, rd, resp);
      check(rd & 32'h3, 32'(m));
      far_u.set_faults(1'b1, 1'b0);
      settle();
      far_u.set_faults(1'b0, 1'b0);
      far_u.sensor_cycle();
      check_state(aea_pkg::CODE_ENC, 1'b0);
      power_cycle();
      check_state(aea_pkg::CODE_NONE, 1'b1);
      axi_read(aea_pkg::OFF_CTRL, rd, resp);
      check(rd & 32'h3, 32'h0);
    end
    tally_and_finish();
  end
endmodule
